// *** hw/evlog_pkg.sv ***
// shared constants and types for the event log and recorder trigger
`default_nettype none
package evlog_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned STAMP_RES_MS = 1;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000 * STAMP_RES_MS;
  localparam logic [26:0] MS_PER_DAY   = 27'h5265c00;
  localparam int unsigned CYC_W        = 15;
  localparam int unsigned DAY_W        = 16;
  localparam int unsigned MS_W         = 27;
  localparam int unsigned FV_W         = 16;
  localparam int unsigned CH_W         = 6;
  localparam int unsigned NUM_W        = 6;
  localparam int unsigned IDX_W        = 11;
  localparam int unsigned STAGES       = 8;
  localparam int unsigned KINDS        = 4;
  localparam int unsigned EV_N         = STAGES * KINDS;
  localparam int unsigned DI_N         = 8;
  localparam int unsigned REC_SEL_N    = 16;
  localparam int unsigned REC_MAX_CH   = 12;
  localparam logic [IDX_W-1:0] DEF_SIZE = 11'h0c8;
  localparam logic [IDX_W-1:0] MIN_SIZE = 11'h032;
  localparam logic [IDX_W-1:0] MAX_SIZE = 11'h7d0;
  localparam int unsigned DEPTH        = 2000;
  localparam logic [CH_W-1:0] STAGE_CH_BASE = 6'h01;
  localparam logic [NUM_W-1:0] K_START_ON  = 6'h00;
  localparam logic [NUM_W-1:0] K_START_OFF = 6'h01;
  localparam logic [NUM_W-1:0] K_TRIP_ON   = 6'h02;
  localparam logic [NUM_W-1:0] K_TRIP_OFF  = 6'h03;
  localparam int unsigned SCALE_SHIFT  = 8;

  typedef struct packed {
    logic                overflow_marker;
    logic [FV_W-1:0]     fault;
    logic [CH_W-1:0]     event_channel_field;
    logic [NUM_W-1:0]    event_number_field;
    logic [DAY_W-1:0]    day;
    logic [MS_W-1:0]     ms;
  } evlog_entry_s;
endpackage
`default_nettype wire

// *** hw/evlog_stamp.sv ***
// millisecond time-of-day and day counter for event stamps
`default_nettype none
module evlog_stamp #(
  parameter int unsigned CLK_PER_MS = evlog_pkg::CYC_PER_MS
) (
  input  wire logic                       clk_in,     // system clock
  input  wire logic                       sys_rst_in, // async reset
  input  wire logic                       set_in,     // load time
  input  wire logic [evlog_pkg::DAY_W-1:0] day_in,    // day to load
  input  wire logic [evlog_pkg::MS_W-1:0]  ms_in,     // ms of day to load
  output logic      [evlog_pkg::DAY_W-1:0] day_out,   // current day
  output logic      [evlog_pkg::MS_W-1:0]  ms_out     // current ms of day
);
  typedef struct packed {
    logic [evlog_pkg::CYC_W-1:0] cyc;
    logic [evlog_pkg::DAY_W-1:0] day;
    logic [evlog_pkg::MS_W-1:0]  ms;
  } evlog_stamp_s;
  evlog_stamp_s q, d;

  always_comb begin
    d = q;
    if (set_in) begin
      d.cyc = '0;
      d.day = day_in;
      d.ms  = ms_in;
    end else if (q.cyc == evlog_pkg::CYC_W'(CLK_PER_MS - 1)) begin
      d.cyc = '0;
      if (q.ms == evlog_pkg::MS_PER_DAY - 27'h1) begin
        d.ms  = '0;
        d.day = q.day + 16'h1;
      end else begin
        d.ms = q.ms + 27'h1;
      end
    end else begin
      d.cyc = q.cyc + 15'h1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign day_out = q.day;
  assign ms_out  = q.ms;
endmodule // evlog_stamp
`default_nettype wire

// *** hw/evlog_trig.sv ***
// disturbance recorder trigger, channel limit and capture stamp
`default_nettype none
module evlog_trig (
  input  wire logic                             clk_in,       // system clock
  input  wire logic                             sys_rst_in,   // async reset
  input  wire logic [evlog_pkg::STAGES-1:0]     start_in,     // stage starts
  input  wire logic [evlog_pkg::STAGES-1:0]     trip_in,      // stage trips
  input  wire logic [evlog_pkg::DI_N-1:0]       di_in,        // digital inputs
  input  wire logic [evlog_pkg::STAGES-1:0]     start_sel_in, // start column
  input  wire logic [evlog_pkg::STAGES-1:0]     trip_sel_in,  // trip column
  input  wire logic [evlog_pkg::DI_N-1:0]       di_sel_in,    // input column
  input  wire logic                             manual_in,    // manual trigger
  input  wire logic [evlog_pkg::REC_SEL_N-1:0]  chan_sel_in,  // wanted channels
  input  wire logic [evlog_pkg::DAY_W-1:0]      day_in,       // current day
  input  wire logic [evlog_pkg::MS_W-1:0]       ms_in,        // current ms
  output logic                                  trig_out,     // capture pulse
  output logic      [evlog_pkg::REC_SEL_N-1:0]  chan_out,     // granted channels
  output logic      [evlog_pkg::DAY_W-1:0]      day_out,      // capture day
  output logic      [evlog_pkg::MS_W-1:0]       ms_out        // capture ms
);
  typedef struct packed {
    logic                            armed_src;
    logic                            trig;
    logic [evlog_pkg::REC_SEL_N-1:0] chan;
    logic [evlog_pkg::DAY_W-1:0]     day;
    logic [evlog_pkg::MS_W-1:0]      ms;
  } evlog_trig_s;
  evlog_trig_s q, d;
  logic src;
  int unsigned granted;

  always_comb begin
    src = |(start_in & start_sel_in) | |(trip_in & trip_sel_in)
        | |(di_in & di_sel_in);
    granted = 0;
    d = q;
    d.armed_src = src;
    d.trig = (src & ~q.armed_src) | manual_in;
    // keep the lowest channels so a capture never exceeds the limit
    for (int i = 0; i < evlog_pkg::REC_SEL_N; i++) begin
      d.chan[i] = chan_sel_in[i] && (granted < evlog_pkg::REC_MAX_CH);
      if (chan_sel_in[i]) begin
        granted = granted + 1;
      end
    end
    if (d.trig) begin
      d.day = day_in;
      d.ms  = ms_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign trig_out = q.trig;
  assign chan_out = q.chan;
  assign day_out  = q.day;
  assign ms_out   = q.ms;
endmodule // evlog_trig
`default_nettype wire

// *** hw/evlog_top.sv ***
// circular event log with remote and panel readers, recorder trigger
`default_nettype none
module evlog_top #(
  parameter int unsigned CLK_PER_MS = evlog_pkg::CYC_PER_MS
) (
  input  wire logic                     clk_in,          // 25 MHz clock
  input  wire logic                     sys_rst_in,      // async reset
  input  wire logic [7:0]               stage_start_in,  // stage starts
  input  wire logic [7:0]               stage_trip_in,   // stage trips
  input  wire logic [15:0]              fault_value_in,  // fault, per unit
  input  wire logic [31:0]              event_mask_in,   // 1 = masked
  input  wire logic [10:0]              buffer_size_in,  // capacity
  input  wire logic                     buffer_clear_cmd,// clear pulse
  input  wire logic                     rd_req_in,       // remote read
  input  wire logic                     reread_req_in,   // remote reread
  input  wire logic                     pan_next_in,     // panel forward
  input  wire logic                     pan_prev_in,     // panel back
  input  wire logic                     order_new_in,    // 1 = newest first
  input  wire logic                     fault_value_scaling, // 1 = primary
  input  wire logic [15:0]              pri_ratio_in,    // primary ratio
  input  wire logic                     time_set_in,     // load clock
  input  wire logic [15:0]              time_day_in,     // day to load
  input  wire logic [26:0]              time_ms_in,      // ms to load
  input  wire logic [7:0]               digital_input_states, // inputs
  input  wire logic [7:0]               rec_start_sel_in,// trigger starts
  input  wire logic [7:0]               rec_trip_sel_in, // trigger trips
  input  wire logic [7:0]               recorder_trigger_column, // inputs
  input  wire logic                     rec_manual_in,   // manual trigger
  input  wire logic [15:0]              rec_chan_sel_in, // wanted channels
  output logic                          rem_valid_out,   // answer pulse
  output logic                          rem_empty_out,   // nothing to give
  output logic [5:0]                    rem_channel_out, // channel field
  output logic [5:0]                    rem_number_out,  // number field
  output logic [15:0]                   rem_fault_out,   // scaled fault
  output logic [15:0]                   rem_day_out,     // stamp day
  output logic [26:0]                   rem_ms_out,      // stamp ms
  output logic                          pan_valid_out,   // panel has entry
  output logic [5:0]                    pan_channel_out, // channel field
  output logic [5:0]                    pan_number_out,  // number field
  output logic [15:0]                   pan_fault_out,   // scaled fault
  output logic [15:0]                   pan_day_out,     // stamp day
  output logic [26:0]                   pan_ms_out,      // stamp ms
  output logic                          overflow_marker, // panel OVF tag
  output logic [10:0]                   event_count_out, // stored events
  output logic                          overflow_out,    // lost entries
  output logic                          rec_trig_out,    // capture pulse
  output logic [15:0]                   rec_chan_out,    // granted chans
  output logic [15:0]                   rec_day_out,     // capture day
  output logic [26:0]                   rec_ms_out       // capture ms
);
  localparam int unsigned IW = evlog_pkg::IDX_W;

  typedef struct packed {
    evlog_pkg::evlog_entry_s [evlog_pkg::DEPTH-1:0] mem;
    logic [IW-1:0]               wr;
    logic [IW-1:0]               rd;
    logic [IW-1:0]               last;
    logic [IW-1:0]               cnt;
    logic [IW-1:0]               unread;
    logic [IW-1:0]               size;
    logic [IW-1:0]               pan;
    logic                        ovf;
    logic                        given;
    logic [evlog_pkg::EV_N-1:0]  pend;
    logic [evlog_pkg::STAGES-1:0] prev_st;
    logic [evlog_pkg::STAGES-1:0] prev_tr;
    logic                        rem_vld;
    logic                        rem_emp;
    evlog_pkg::evlog_entry_s     rem_e;
    logic [15:0]                 rem_fv;
    logic                        pan_vld;
    evlog_pkg::evlog_entry_s     pan_e;
    logic [15:0]                 pan_fv;
  } evlog_top_s;
  evlog_top_s q, d;

  logic [15:0] now_day;
  logic [26:0] now_ms;

  function automatic logic [IW-1:0] wrap_inc(
    input logic [IW-1:0] i,
    input logic [IW-1:0] sz
  );
    return (i == sz - 11'h1) ? '0 : i + 11'h1;
  endfunction

  function automatic logic [IW-1:0] wrap_add(
    input logic [IW-1:0] b,
    input logic [IW-1:0] o,
    input logic [IW-1:0] sz
  );
    logic [IW:0] s;
    s = {1'b0, b} + {1'b0, o};
    if (s >= {1'b0, sz}) begin
      s = s - {1'b0, sz};
    end
    return s[IW-1:0];
  endfunction

  function automatic logic [IW-1:0] wrap_sub(
    input logic [IW-1:0] b,
    input logic [IW-1:0] o,
    input logic [IW-1:0] sz
  );
    logic [IW:0] s;
    s = {1'b0, b} + {1'b0, sz} - {1'b0, o};
    if (s >= {1'b0, sz}) begin
      s = s - {1'b0, sz};
    end
    return s[IW-1:0];
  endfunction

  function automatic logic [IW-1:0] clamp_size(input logic [IW-1:0] v);
    if (v < evlog_pkg::MIN_SIZE) begin
      return evlog_pkg::MIN_SIZE;
    end
    if (v > evlog_pkg::MAX_SIZE) begin
      return evlog_pkg::MAX_SIZE;
    end
    return v;
  endfunction

  // fault shown per unit or through the primary ratio
  function automatic logic [15:0] scale_fv(
    input logic [15:0] fv,
    input logic        pri,
    input logic [15:0] ratio
  );
    logic [31:0] p;
    p = {16'h0, fv} * {16'h0, ratio};
    if (pri) begin
      return p[evlog_pkg::SCALE_SHIFT +: 16];
    end
    return fv;
  endfunction

  evlog_stamp #(
    .CLK_PER_MS (CLK_PER_MS)
  ) u_stamp (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .set_in     (time_set_in),
    .day_in     (time_day_in),
    .ms_in      (time_ms_in),
    .day_out    (now_day),
    .ms_out     (now_ms)
  );

  evlog_trig u_trig (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .start_in     (stage_start_in),
    .trip_in      (stage_trip_in),
    .di_in        (digital_input_states),
    .start_sel_in (rec_start_sel_in),
    .trip_sel_in  (rec_trip_sel_in),
    .di_sel_in    (recorder_trigger_column),
    .manual_in    (rec_manual_in),
    .chan_sel_in  (rec_chan_sel_in),
    .day_in       (now_day),
    .ms_in        (now_ms),
    .trig_out     (rec_trig_out),
    .chan_out     (rec_chan_out),
    .day_out      (rec_day_out),
    .ms_out       (rec_ms_out)
  );

  logic [evlog_pkg::EV_N-1:0] trans;
  logic [evlog_pkg::EV_N-1:0] pend;
  logic                       pick_vld;
  logic [4:0]                 pick;
  logic [IW-1:0]              oldest;
  logic [IW-1:0]              pidx;
  evlog_pkg::evlog_entry_s    ne;

  always_comb begin
    trans    = '0;
    pend     = '0;
    pick_vld = 1'b0;
    pick     = '0;
    oldest   = '0;
    pidx     = '0;
    ne       = '0;
    d = q;
    d.rem_vld = 1'b0;
    d.rem_emp = 1'b0;
    d.prev_st = stage_start_in;
    d.prev_tr = stage_trip_in;
    for (int s = 0; s < evlog_pkg::STAGES; s++) begin
      trans[s*4+0] = stage_start_in[s] & ~q.prev_st[s];
      trans[s*4+1] = ~stage_start_in[s] & q.prev_st[s];
      trans[s*4+2] = stage_trip_in[s] & ~q.prev_tr[s];
      trans[s*4+3] = ~stage_trip_in[s] & q.prev_tr[s];
    end
    if (buffer_clear_cmd) begin
      // edges arriving with the clear are dropped with the log
      d.wr     = '0;
      d.rd     = '0;
      d.last   = '0;
      d.cnt    = '0;
      d.unread = '0;
      d.pan    = '0;
      d.ovf    = 1'b0;
      d.given  = 1'b0;
      d.pend   = '0;
      d.size   = clamp_size(buffer_size_in);
    end else begin
      pend = q.pend | (trans & ~event_mask_in);
      // remote side first, so a read in the same cycle frees room
      if (rd_req_in) begin
        d.rem_vld = 1'b1;
        if (q.unread != '0) begin
          d.rem_e  = q.mem[q.rd];
          d.last   = q.rd;
          d.rd     = wrap_inc(q.rd, q.size);
          d.unread = q.unread - 11'h1;
          d.given  = 1'b1;
        end else begin
          d.rem_emp = 1'b1;
        end
      end else if (reread_req_in) begin
        d.rem_vld = 1'b1;
        if (q.given) begin
          d.rem_e = q.mem[q.last];
        end else begin
          d.rem_emp = 1'b1;
        end
      end
      // one event per cycle, lowest code wins
      for (int i = evlog_pkg::EV_N - 1; i >= 0; i--) begin
        if (pend[i]) begin
          pick_vld = 1'b1;
          pick     = 5'(i);
        end
      end
      if (pick_vld) begin
        pend[pick] = 1'b0;
        ne.fault = fault_value_in;
        ne.event_channel_field = evlog_pkg::STAGE_CH_BASE + 6'(pick[4:2]);
        case (pick[1:0])
          2'h0:    ne.event_number_field = evlog_pkg::K_START_ON;
          2'h1:    ne.event_number_field = evlog_pkg::K_START_OFF;
          2'h2:    ne.event_number_field = evlog_pkg::K_TRIP_ON;
          default: ne.event_number_field = evlog_pkg::K_TRIP_OFF;
        endcase
        ne.day = now_day;
        ne.ms  = now_ms;
        if (d.unread == q.size) begin
          // unpolled host: oldest unread entry is lost
          ne.overflow_marker = 1'b1;
          d.ovf = 1'b1;
          d.rd  = wrap_inc(d.rd, q.size);
        end else begin
          d.unread = d.unread + 11'h1;
        end
        d.mem[q.wr] = ne;
        d.wr = wrap_inc(q.wr, q.size);
        if (q.cnt != q.size) begin
          d.cnt = q.cnt + 11'h1;
        end
      end
      d.pend = pend;
      if (pan_next_in && (q.pan + 11'h1 < d.cnt)) begin
        d.pan = q.pan + 11'h1;
      end else if (pan_prev_in && (q.pan != '0)) begin
        d.pan = q.pan - 11'h1;
      end
    end
    oldest = wrap_sub(d.wr, d.cnt, d.size);
    if (order_new_in) begin
      pidx = wrap_sub(wrap_sub(d.wr, 11'h1, d.size), d.pan, d.size);
    end else begin
      pidx = wrap_add(oldest, d.pan, d.size);
    end
    d.pan_vld = (d.cnt != '0);
    d.pan_e   = d.mem[pidx];
    // fold the valid term in here so the marker pin comes straight off a flop
    d.pan_e.overflow_marker = d.pan_e.overflow_marker & d.pan_vld;
    d.pan_fv  = scale_fv(d.pan_e.fault, fault_value_scaling, pri_ratio_in);
    d.rem_fv  = scale_fv(d.rem_e.fault, fault_value_scaling, pri_ratio_in);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q      <= '0;
      q.size <= evlog_pkg::DEF_SIZE;
    end else begin
      q <= d;
    end
  end

  assign rem_valid_out   = q.rem_vld;
  assign rem_empty_out   = q.rem_emp;
  assign rem_channel_out = q.rem_e.event_channel_field;
  assign rem_number_out  = q.rem_e.event_number_field;
  assign rem_fault_out   = q.rem_fv;
  assign rem_day_out     = q.rem_e.day;
  assign rem_ms_out      = q.rem_e.ms;
  assign pan_valid_out   = q.pan_vld;
  assign pan_channel_out = q.pan_e.event_channel_field;
  assign pan_number_out  = q.pan_e.event_number_field;
  assign pan_fault_out   = q.pan_fv;
  assign pan_day_out     = q.pan_e.day;
  assign pan_ms_out      = q.pan_e.ms;
  assign overflow_marker = q.pan_e.overflow_marker;
  assign event_count_out = q.cnt;
  assign overflow_out    = q.ovf;
endmodule // evlog_top
`default_nettype wire

// *** test/evlog_assertions.sv ***
// port-level assertions for the event log top
`default_nettype none
module evlog_assertions (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        rd_req_in,
  input wire logic        reread_req_in,
  input wire logic        buffer_clear_cmd,
  input wire logic [7:0]  stage_start_in,
  input wire logic [7:0]  stage_trip_in,
  input wire logic [7:0]  digital_input_states,
  input wire logic [7:0]  rec_start_sel_in,
  input wire logic [7:0]  rec_trip_sel_in,
  input wire logic [7:0]  recorder_trigger_column,
  input wire logic        rec_manual_in,
  input wire logic        rem_valid_out,
  input wire logic        rem_empty_out,
  input wire logic [5:0]  rem_channel_out,
  input wire logic [5:0]  rem_number_out,
  input wire logic [15:0] rem_day_out,
  input wire logic [26:0] rem_ms_out,
  input wire logic [10:0] event_count_out,
  input wire logic        overflow_out,
  input wire logic        rec_trig_out,
  input wire logic [15:0] rec_chan_out,
  input wire logic [15:0] rec_day_out,
  input wire logic [26:0] rec_ms_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // any selected source, as the recorder sees it
  wire trig_src = |(stage_start_in & rec_start_sel_in) | |(stage_trip_in & rec_trip_sel_in)
                  | |(digital_input_states & recorder_trigger_column);

  a_read_answer: assert property ((rd_req_in && !buffer_clear_cmd) |=> rem_valid_out)
    else $error("read not answered");
  a_reread_answer: assert property ((reread_req_in && !buffer_clear_cmd) |=> rem_valid_out)
    else $error("reread not answered");
  a_no_stray: assert property (rem_valid_out |-> $past(rd_req_in || reread_req_in))
    else $error("answer without request");
  a_reread_same: assert property ((reread_req_in && !rd_req_in && !buffer_clear_cmd) |=>
    $stable(rem_channel_out) && $stable(rem_number_out) && $stable(rem_day_out)
    && $stable(rem_ms_out)) else $error("reread changed the entry");
  a_empty_valid: assert property (rem_empty_out |-> rem_valid_out)
    else $error("empty without answer");
  a_clear_all: assert property (buffer_clear_cmd |=>
    event_count_out == 11'h000 && !overflow_out)
    else $error("clear left state behind");
  a_ovf_sticky: assert property (overflow_out && !buffer_clear_cmd |=> overflow_out)
    else $error("overflow flag dropped");
  a_count_cap: assert property (event_count_out <= 11'h7d0)
    else $error("count above largest size");
  a_chan_limit: assert property ($countones(rec_chan_out) <= 12)
    else $error("too many recorder channels");
  a_src_trig: assert property ($rose(trig_src) |=> rec_trig_out)
    else $error("selected source did not trigger");
  a_manual_trig: assert property (rec_manual_in |=> rec_trig_out)
    else $error("manual trigger ignored");
  a_stamp_held: assert property (!rec_trig_out |->
    $stable(rec_ms_out) && $stable(rec_day_out))
    else $error("capture stamp moved without capture");
endmodule // evlog_assertions
`default_nettype wire

// *** test/evlog_host.sv ***
// remote host model: polls the log and keeps the last answer
`default_nettype none
module evlog_host (
  input  wire logic       clk_in,        // system clock
  input  wire logic       poll_in,       // read next entry
  input  wire logic       again_in,      // ask for last entry again
  input  wire logic       rem_valid_in,  // answer strobe
  input  wire logic       rem_empty_in,  // nothing to give
  input  wire logic [5:0] rem_number_in, // number field
  output logic            rd_req_out,    // read request
  output logic            reread_out,    // reread request
  output logic      [5:0] got_num_out,   // last number taken
  output logic            got_empty_out  // last answer was empty
);
  assign rd_req_out = poll_in;
  assign reread_out = again_in;
  always_ff @(posedge clk_in) begin
    if (rem_valid_in) begin
      got_num_out   <= rem_number_in;
      got_empty_out <= rem_empty_in;
    end
  end
endmodule // evlog_host
`default_nettype wire

// *** test/evlog_top_tb.sv ***
// self-checking bench for the event log top
`default_nettype none
module evlog_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, sys_rst_in = 1, buffer_clear_cmd = 0, pan_next_in = 0, pan_prev_in = 0;
  logic [7:0] stage_start_in = 0, stage_trip_in = 0, digital_input_states = 0;
  logic [7:0] rec_start_sel_in = 0, rec_trip_sel_in = 0, recorder_trigger_column = 0;
  logic [15:0] fault_value_in = 0, pri_ratio_in = 0, time_day_in = 0, rec_chan_sel_in = 0;
  logic [31:0] event_mask_in = 0;
  logic [10:0] buffer_size_in = 0, event_count_out;
  logic order_new_in = 0, fault_value_scaling = 0, time_set_in = 0, rec_manual_in = 0;
  logic poll = 0, again = 0, rd_req_in, reread_req_in, rem_valid_out, rem_empty_out;
  logic [26:0] time_ms_in = 0, rem_ms_out, pan_ms_out, rec_ms_out;
  logic pan_valid_out, overflow_marker, overflow_out, rec_trig_out, got_empty;
  logic [5:0] rem_channel_out, rem_number_out, pan_channel_out, pan_number_out, got_num;
  logic [15:0] rem_fault_out, rem_day_out, pan_fault_out, pan_day_out, rec_chan_out, rec_day_out;
  int fails = 0, total_checks = 0, cyc = 0;

  // short millisecond keeps stamp tests brief
  evlog_top #(.CLK_PER_MS(4)) evlog_top_i (.*);
  evlog_host evlog_host_i (.clk_in(clk_in), .poll_in(poll), .again_in(again),
    .rem_valid_in(rem_valid_out), .rem_empty_in(rem_empty_out), .rem_number_in(rem_number_out),
    .rd_req_out(rd_req_in), .reread_out(reread_req_in), .got_num_out(got_num),
    .got_empty_out(got_empty));

  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // k: 0 start on, 1 start off, 2 trip on, 3 trip off
  task automatic ev(input int s, input int k);
    if (k < 2) stage_start_in[s] = (k == 0);
    else stage_trip_in[s] = (k == 2);
    tick(2);
  endtask
  task automatic rd(input bit re);
    if (re) again = 1;
    else poll = 1;
    tick(1);
    poll = 0;
    again = 0;
    tick(1);
  endtask
  task automatic pulse(ref logic sig);
    sig = 1;
    tick(1);
    sig = 0;
    tick(1);
  endtask
  task automatic watch(input bit man);
    logic [3:0] hit;
    hit = 0;
    rec_manual_in = man;
    repeat (3) begin
      tick(1);
      rec_manual_in = 0;
      hit = hit + 4'(rec_trig_out);
    end
    check(hit, 4'h1);
  endtask

  task automatic t_codes();
    event_mask_in = 32'h0000_0010; // stage 1 start-on masked
    for (int k = 0; k < 4; k++) ev(0, k);
    ev(1, 0);
    check(event_count_out, 11'h004);
    for (int k = 0; k < 4; k++) begin
      rd(0);
      check({rem_channel_out, rem_number_out}, {6'h01, 6'(k)});
    end
    rd(1);
    check({got_empty, got_num}, {1'b0, 6'h03});
    rd(0);
    check(got_empty, 1'b1);
    ev(1, 1);
    rd(0);
    check({rem_channel_out, got_num}, {6'h02, 6'h01});
  endtask
  task automatic t_stamp();
    time_day_in = 16'h0005;
    time_ms_in = 27'd1000;
    pulse(time_set_in);
    ev(2, 2);
    rd(0);
    check(rem_day_out, 16'h0005);
    check(rem_ms_out >= 27'd1000 && rem_ms_out <= 27'd1001, 1'b1);
    time_ms_in = evlog_pkg::MS_PER_DAY - 27'h1;
    pulse(time_set_in);
    tick(8);
    ev(2, 3);
    rd(0);
    check(rem_day_out, 16'h0006);
  endtask
  task automatic t_scale();
    fault_value_in = 16'h0200;
    pri_ratio_in = 16'h0300;
    ev(3, 0);
    rd(0);
    check(rem_fault_out, 16'h0200);
    fault_value_scaling = 1;
    tick(2);
    check(rem_fault_out, 16'h0600);
  endtask
  task automatic t_overflow();
    buffer_size_in = 11'h00a; // below the floor, must clamp
    pulse(buffer_clear_cmd);
    check({event_count_out, overflow_out}, 12'h000);
    time_ms_in = 27'h0;
    pulse(time_set_in);
    for (int i = 0; i < 51; i++) ev(4, i % 2);
    check({event_count_out, overflow_out}, {11'h032, 1'b1});
    rd(0);
    check(got_num, 6'h01);
    check({pan_channel_out, pan_number_out}, {6'h05, 6'h01});
    check({pan_day_out, pan_ms_out, pan_fault_out}, {16'h0005, 27'h0, 16'h0600});
    pulse(pan_next_in);
    check(pan_number_out, 6'h00);
    pulse(pan_prev_in);
    pulse(pan_prev_in);
    check(pan_number_out, 6'h01);
    order_new_in = 1;
    tick(2);
    check({overflow_marker, pan_number_out}, {1'b1, 6'h00});
    order_new_in = 0;
    buffer_size_in = 11'h7ff;
    pulse(buffer_clear_cmd);
    check({event_count_out, overflow_out, pan_valid_out}, 13'h0000);
    rd(1);
    check(got_empty, 1'b1);
  endtask
  task automatic t_recorder();
    time_day_in = 16'h0009;
    time_ms_in = 27'h1f4;
    pulse(time_set_in);
    rec_chan_sel_in = 16'hffff;
    rec_start_sel_in = 8'h01;
    tick(2);
    check(rec_chan_out, 16'h0fff);
    stage_start_in[0] = 1;
    watch(0);
    check(rec_day_out, 16'h0009);
    check(rec_ms_out, 27'h1f4);
    watch(1);
  endtask
  task automatic t_default();
    sys_rst_in = 1;
    tick(2);
    sys_rst_in = 0;
    tick(1);
    for (int i = 0; i < 201; i++) ev(5, i % 2);
    check({event_count_out, overflow_out}, {11'h0c8, 1'b1});
  endtask

  initial begin
    tick(10);
    sys_rst_in = 0;
    tick(1);
    check({event_count_out, overflow_out, rem_valid_out}, 13'h0000);
    t_codes();
    t_stamp();
    t_scale();
    t_overflow();
    t_recorder();
    t_default();
    tally_and_finish();
  end
endmodule // evlog_top_tb

bind evlog_top evlog_assertions evlog_assertions_i (.*);
`default_nettype wire
